// ### design/pfc_line_table.sv
`timescale 1ns/10ps
`default_nettype none
module pfc_line_table #(
  parameter int unsigned DEPTH = pfc_pkg::LINES
) (
  // Clock
  input wire logic clk_i,
  // Table port
  pfc_tbl_if.mem   tbl
);
  import pfc_pkg::*;

  logic [ENT_W-1:0] forms_line_table [DEPTH];

  // One entry per print line; contents are undefined until loaded [R1]
  always_ff @(posedge clk_i) begin
    if (tbl.wr_en && tbl.wr_addr < POS_W'(DEPTH)) begin
      forms_line_table[tbl.wr_addr] <= tbl.wr_data;
    end
  end

  // Asynchronous read so the controller sees the entry at its position at once
  assign tbl.rd_data = (tbl.rd_addr < POS_W'(DEPTH)) ? forms_line_table[tbl.rd_addr]
                                                     : '0;
endmodule : pfc_line_table
`default_nettype wire

// ### design/pfc_pkg.sv
package pfc_pkg;

  // Table geometry
  localparam int unsigned LINES    = 180;
  localparam int unsigned POS_W    = 8;
  localparam int unsigned ENT_W    = 6;
  localparam int unsigned CODE_LSB = 0;
  localparam int unsigned CODE_W   = 4;
  localparam int unsigned EOF_BIT  = 4;
  localparam int unsigned LPI_BIT  = 5;

  // Channel codes and positions
  localparam logic [CODE_W-1:0] CODE_NONE = 4'h0;
  localparam logic [CODE_W-1:0] CODE_MAX  = 4'hc;
  localparam logic [POS_W-1:0]  POS_FIRST = 8'h01;
  localparam logic [POS_W-1:0]  POS_LAST  = 8'hb4;
  localparam logic [POS_W-1:0]  ADDR_LAST = 8'hb3;
  localparam logic [1:0]        ONES_LIMIT = 2'h2;

  // Sense layout, six bytes
  localparam int unsigned SENSE_W           = 48;
  localparam int unsigned SNS_LOAD_ERR      = 0;
  localparam int unsigned SNS_RUNAWAY       = 1;
  localparam int unsigned SNS_NOT_LOADED    = 2;
  localparam int unsigned SNS_CMD_REJ       = 3;
  localparam int unsigned SNS_PRINT_PARITY  = 8;
  localparam int unsigned SNS_UNIT_FAULT    = 9;
  localparam int unsigned SNS_PRINTER_FAULT = 10;

  // Reset values
  localparam logic [SENSE_W-1:0] SENSE_RST = 48'h0;
  localparam logic               LPI8_RST  = 1'b0;

  typedef enum logic [1:0] {
    PFC_OP_SPACE = 2'h0,
    PFC_OP_SKIP  = 2'h1,
    PFC_OP_LOAD  = 2'h2,
    PFC_OP_NOP   = 2'h3
  } pfc_op_t;

  typedef enum logic [3:0] {
    ST_IDLE  = 4'h1,
    ST_LOAD  = 4'h2,
    ST_SPACE = 4'h4,
    ST_SKIP  = 4'h8
  } pfc_state_t;

  // Line after pos; wraps after the flagged last line or the physical end
  function automatic logic [POS_W-1:0] pfc_next_pos(input logic [POS_W-1:0] pos,
                                                   input logic             last);
    return (last || pos == POS_LAST) ? POS_FIRST : pos + 8'h01;
  endfunction : pfc_next_pos

endpackage : pfc_pkg

// ### design/pfc_tbl_if.sv
`timescale 1ns/10ps
`default_nettype none
interface pfc_tbl_if;
  import pfc_pkg::*;
  logic             wr_en;
  logic [POS_W-1:0] wr_addr;
  logic [ENT_W-1:0] wr_data;
  logic [POS_W-1:0] rd_addr;
  logic [ENT_W-1:0] rd_data;

  modport ctrl (output wr_en, wr_addr, wr_data, rd_addr, input rd_data);
  modport mem  (input wr_en, wr_addr, wr_data, rd_addr, output rd_data);
endinterface : pfc_tbl_if
`default_nettype wire

// ### design/pfc_top.sv
// Functional notes
// R1: The unit holds a 180-entry line table, one entry per carriage space.
// R2: Each entry can carry a channel code from 1 to 12 marking a skip target.
// R3: A line-position register indexes the table and steps on every line fed.
// R4: An advance_to_tagged_line command feeds until the current entry holds the channel.
// R5: If the channel is absent, feeding stops when line 1 is reached for the second time.
// R6: An end-of-form flag marks the final line of a short form.
// R7: A flag in the first entry selects 8 or 6 lines per inch.
// R8: The host fills the table with the line_table_load_command.
// R9: A load without end-of-form flag or with a bad channel code is an error.
// R10: Malfunctions are reported as six sense bytes.
// R11: A retryable print parity error is sensed and inhibits carriage motion.
// R12: Feeding past the last-line entry returns the position to line 1.
// R13: The host loads a valid table before space or skip commands.
`timescale 1ns/10ps
`default_nettype none
module pfc_top (
  // Clock and reset
  input  wire logic                        clk_i,
  input  wire logic                        rst_i,
  // Host command
  input  wire logic                        cmd_valid_i,
  input  wire pfc_pkg::pfc_op_t            cmd_op_i,
  input  wire logic [3:0]                  cmd_arg_i,
  output var  logic                        cmd_ready_o,
  output var  logic                        cmd_done_o,
  // Table load data
  input  wire logic                        load_valid_i,
  input  wire logic [pfc_pkg::ENT_W-1:0]   load_data_i,
  input  wire logic                        load_last_i,
  output var  logic                        load_ready_o,
  // Carriage
  input  wire logic                        carriage_ready_i,
  output var  logic                        feed_step_o,
  output var  logic                        lpi8_o,
  output var  logic [pfc_pkg::POS_W-1:0]   line_pos_o,
  // Faults and sense
  input  wire logic                        print_parity_err_i,
  input  wire logic                        unit_fault_i,
  input  wire logic                        printer_fault_i,
  input  wire logic                        sense_clear_i,
  output var  logic                        motion_inhibit_o,
  output var  logic                        table_valid_o,
  output var  logic [pfc_pkg::SENSE_W-1:0] sense_o
);
  import pfc_pkg::*;

  pfc_tbl_if tbl ();

  pfc_line_table #(.DEPTH(LINES)) u_table (
    .clk_i (clk_i),
    .tbl   (tbl)
  );

  pfc_state_t          state,      next_state;
  logic [POS_W-1:0]    load_addr,  next_load_addr;
  logic                eof_seen,   next_eof_seen;
  logic                bad_code,   next_bad_code;
  logic [1:0]          remaining,  next_remaining;
  logic [CODE_W-1:0]   target,     next_target;
  logic [1:0]          ones_seen,  next_ones_seen;
  logic                moved,      next_moved;
  logic                next_ready, next_load_ready, next_done, next_feed;
  logic                next_lpi8,  next_valid, next_inhibit;
  logic [POS_W-1:0]    next_pos;
  logic [SENSE_W-1:0]  next_sense;
  logic [CODE_W-1:0]   cur_code, ld_code;
  logic                cur_last, cmd_take, step_ok;

  // Table addressing: entry index is position minus one
  assign tbl.rd_addr = line_pos_o - 8'h01;
  assign tbl.wr_en   = (state == ST_LOAD) && load_valid_i;
  assign tbl.wr_addr = load_addr;
  assign tbl.wr_data = load_data_i;
  assign cur_code    = tbl.rd_data[CODE_LSB +: CODE_W];
  assign cur_last    = tbl.rd_data[EOF_BIT];
  assign ld_code     = load_data_i[CODE_LSB +: CODE_W];
  assign cmd_take    = cmd_valid_i && cmd_ready_o;
  // Inhibit is the registered flag, so a feed decided in the parity error's own cycle still goes; feeds stop from the next cycle
  assign step_ok     = carriage_ready_i && !motion_inhibit_o;

  // Command sequencer, next values
  always_comb begin
    next_state      = state;
    next_load_addr  = load_addr;
    next_eof_seen   = eof_seen;
    next_bad_code   = bad_code;
    next_remaining  = remaining;
    next_target     = target;
    next_ones_seen  = ones_seen;
    next_moved      = 1'b0;
    next_done       = 1'b0;
    next_feed       = 1'b0;
    next_lpi8       = lpi8_o;
    next_valid      = table_valid_o;
    next_pos        = line_pos_o;
    next_sense      = sense_clear_i ? SENSE_RST : sense_o;
    unique case (state)
      ST_IDLE: begin
        if (cmd_take) begin
          unique case (cmd_op_i)
            PFC_OP_LOAD: begin
              next_state     = ST_LOAD;
              next_load_addr = '0;
              next_eof_seen  = 1'b0;
              next_bad_code  = 1'b0;
              next_valid     = 1'b0;
            end
            PFC_OP_SPACE, PFC_OP_SKIP: begin
              if (!table_valid_o) begin
                next_sense[SNS_NOT_LOADED] = 1'b1;
                next_done                  = 1'b1;
              end else if (cmd_op_i == PFC_OP_SKIP &&
                           (cmd_arg_i == CODE_NONE || cmd_arg_i > CODE_MAX)) begin
                next_sense[SNS_CMD_REJ] = 1'b1;
                next_done               = 1'b1;
              end else if (cmd_op_i == PFC_OP_SKIP) begin
                next_state     = ST_SKIP;
                next_target    = cmd_arg_i;
                next_ones_seen = 2'h0;
              end else begin
                next_state     = ST_SPACE;
                next_remaining = cmd_arg_i[1:0];
              end
            end
            PFC_OP_NOP: next_done = 1'b1;
          endcase
        end
      end
      ST_LOAD: begin
        if (load_valid_i) begin
          if (load_addr == '0) begin
            next_lpi8 = load_data_i[LPI_BIT]; // [R7]
          end
          next_eof_seen  = eof_seen | load_data_i[EOF_BIT];
          next_bad_code  = bad_code | (ld_code > CODE_MAX); // [R2]
          next_load_addr = load_addr + 8'h01;
          if (load_last_i || load_addr == ADDR_LAST) begin
            next_state = ST_IDLE;
            next_done  = 1'b1;
            next_pos   = POS_FIRST;
            next_valid = next_eof_seen && !next_bad_code;
            if (!next_valid) begin
              next_sense[SNS_LOAD_ERR] = 1'b1; // [R9]
            end
          end
        end
      end
      ST_SPACE: begin
        if (remaining == 2'h0) begin
          next_state = ST_IDLE;
          next_done  = 1'b1;
        end else if (step_ok) begin
          next_pos       = pfc_next_pos(line_pos_o, cur_last); // [R3] [R6] [R12]
          next_feed      = 1'b1;
          next_remaining = remaining - 2'h1;
        end
      end
      ST_SKIP: begin
        if (moved && cur_code == target) begin
          next_state = ST_IDLE; // [R4]
          next_done  = 1'b1;
        end else if (moved && line_pos_o == POS_FIRST && ones_seen == ONES_LIMIT - 2'h1) begin
          next_state                = ST_IDLE; // [R5]
          next_done                 = 1'b1;
          next_sense[SNS_RUNAWAY]   = 1'b1;
          next_ones_seen            = ONES_LIMIT;
        end else if (moved) begin
          next_ones_seen = ones_seen + ((line_pos_o == POS_FIRST) ? 2'h1 : 2'h0);
        end else if (step_ok) begin
          next_pos   = pfc_next_pos(line_pos_o, cur_last); // [R3] [R4] [R12]
          next_feed  = 1'b1;
          next_moved = 1'b1;
        end else begin
          next_moved = 1'b0;
        end
      end
    endcase
    // Faults set their sense bits after any clear, so a new event survives [R10] [R11]
    if (print_parity_err_i) next_sense[SNS_PRINT_PARITY]  = 1'b1;
    if (unit_fault_i)       next_sense[SNS_UNIT_FAULT]    = 1'b1;
    if (printer_fault_i)    next_sense[SNS_PRINTER_FAULT] = 1'b1;
    next_inhibit    = print_parity_err_i | (motion_inhibit_o & ~sense_clear_i); // [R11]
    next_ready      = (next_state == ST_IDLE);
    next_load_ready = (next_state == ST_LOAD);
  end

  // Command sequencer, registers
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      state            <= ST_IDLE;
      load_addr        <= '0;
      eof_seen         <= 1'b0;
      bad_code         <= 1'b0;
      remaining        <= 2'h0;
      target           <= CODE_NONE;
      ones_seen        <= 2'h0;
      moved            <= 1'b0;
      cmd_ready_o      <= 1'b1;
      load_ready_o     <= 1'b0;
      cmd_done_o       <= 1'b0;
      feed_step_o      <= 1'b0;
      lpi8_o           <= LPI8_RST;
      table_valid_o    <= 1'b0;
      line_pos_o       <= POS_FIRST;
      sense_o          <= SENSE_RST;
      motion_inhibit_o <= 1'b0;
    end else begin
      state            <= next_state;
      load_addr        <= next_load_addr;
      eof_seen         <= next_eof_seen;
      bad_code         <= next_bad_code;
      remaining        <= next_remaining;
      target           <= next_target;
      ones_seen        <= next_ones_seen;
      moved            <= next_moved;
      cmd_ready_o      <= next_ready;
      load_ready_o     <= next_load_ready;
      cmd_done_o       <= next_done;
      feed_step_o      <= next_feed;
      lpi8_o           <= next_lpi8;
      table_valid_o    <= next_valid;
      line_pos_o       <= next_pos;
      sense_o          <= next_sense;
      motion_inhibit_o <= next_inhibit;
    end
  end

  // Checks on the sequencer
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  sequence s_skip_hit;
    (state == ST_SKIP) && moved && (cur_code == target);
  endsequence

  property p_pos_range;
    (line_pos_o >= POS_FIRST) && (line_pos_o <= POS_LAST);
  endproperty
  a_pos_range: assert property (p_pos_range) else $error("line position out of range"); // [R1]

  property p_step_moves;
    feed_step_o |-> (line_pos_o != $past(line_pos_o));
  endproperty
  a_step_moves: assert property (p_step_moves) else $error("feed without position step"); // [R3]

  property p_skip_hit_stops;
    s_skip_hit |=> (state == ST_IDLE) && cmd_done_o && !feed_step_o;
  endproperty
  a_skip_hit_stops: assert property (p_skip_hit_stops) else $error("skip passed its channel"); // [R4]

  property p_runaway;
    (state == ST_SKIP) && moved && (line_pos_o == POS_FIRST) && (ones_seen == 2'h1)
      && (cur_code != target) |=> sense_o[SNS_RUNAWAY] && (state == ST_IDLE);
  endproperty
  a_runaway: assert property (p_runaway) else $error("runaway skip not stopped"); // [R5]

  property p_wrap_last;
    feed_step_o && $past(cur_last) |-> (line_pos_o == POS_FIRST);
  endproperty
  a_wrap_last: assert property (p_wrap_last) else $error("no wrap after last line"); // [R6]

  property p_lpi_hold;
    (state != ST_LOAD) |=> $stable(lpi8_o);
  endproperty
  a_lpi_hold: assert property (p_lpi_hold) else $error("spacing flag changed outside load"); // [R7]

  property p_load_err;
    (state == ST_LOAD) && load_valid_i && (load_last_i || load_addr == ADDR_LAST)
      && (!(eof_seen || load_data_i[EOF_BIT]) || bad_code || ld_code > CODE_MAX)
      |=> sense_o[SNS_LOAD_ERR] && !table_valid_o;
  endproperty
  a_load_err: assert property (p_load_err) else $error("bad load not flagged"); // [R9]

  property p_fault_sense;
    unit_fault_i || printer_fault_i |=> sense_o[SNS_UNIT_FAULT] || sense_o[SNS_PRINTER_FAULT];
  endproperty
  a_fault_sense: assert property (p_fault_sense) else $error("fault not sensed"); // [R10]

  property p_inhibit;
    print_parity_err_i |=> motion_inhibit_o && sense_o[SNS_PRINT_PARITY] ##1 !feed_step_o;
  endproperty
  a_inhibit: assert property (p_inhibit) else $error("carriage moved after parity error"); // [R11]

endmodule : pfc_top
`default_nettype wire

// ### verification/pfc_host_model.sv
`timescale 1ns/10ps
`default_nettype none
module pfc_host_model (
  // Clock
  input  wire logic                      clk_i,
  // Answers from the unit
  input  wire logic                      cmd_ready_i,
  input  wire logic                      cmd_done_i,
  input  wire logic                      load_ready_i,
  // Requests to the unit
  output var  logic                      cmd_valid_o,
  output var  pfc_pkg::pfc_op_t          cmd_op_o,
  output var  logic [3:0]                cmd_arg_o,
  output var  logic                      load_valid_o,
  output var  logic [pfc_pkg::ENT_W-1:0] load_data_o,
  output var  logic                      load_last_o
);
  import pfc_pkg::*;
  int done_cnt = 0;

  // Done pulses are counted so a one-cycle answer is never missed
  always @(posedge clk_i) begin
    if (cmd_done_i === 1'b1) done_cnt <= done_cnt + 1;
  end

  // Idle channel at time zero
  initial begin
    cmd_valid_o = 1'b0;
    cmd_op_o = PFC_OP_NOP;
    cmd_arg_o = 4'h0;
    load_valid_o = 1'b0;
    load_data_o = 6'h00;
    load_last_o = 1'b0;
  end

  // Request held until an edge that sees ready high
  task automatic send(input pfc_op_t op, input logic [3:0] arg, output int base);
    int n;
    base = done_cnt;
    @(negedge clk_i);
    cmd_valid_o = 1'b1;
    cmd_op_o = op;
    cmd_arg_o = arg;
    for (n = 0; n < 50 && cmd_ready_i !== 1'b1; n++) @(negedge clk_i);
    @(negedge clk_i);
    cmd_valid_o = 1'b0;
    cmd_arg_o = ~arg; // Released argument lines must not keep the old value
  endtask : send

  // Bounded wait for the end of the command
  task automatic wait_done(input int base, output logic ok);
    int n;
    for (n = 0; n < 2000 && done_cnt == base; n++) @(negedge clk_i);
    ok = (done_cnt != base);
  endtask : wait_done

  // Table fill, one entry a cycle, first line first
  task automatic load(input logic [ENT_W-1:0] ent[$], output logic ok);
    int base;
    int n;
    send(PFC_OP_LOAD, 4'h0, base);
    foreach (ent[i]) begin
      for (n = 0; n < 50 && load_ready_i !== 1'b1; n++) @(negedge clk_i);
      load_valid_o = 1'b1;
      load_data_o = ent[i];
      load_last_o = (i == ent.size() - 1);
      @(negedge clk_i);
    end
    load_valid_o = 1'b0;
    load_last_o = 1'b0;
    load_data_o = ~load_data_o;
    wait_done(base, ok);
  endtask : load
endmodule : pfc_host_model
`default_nettype wire

// ### verification/test_printer_forms_control_buffer.sv
`timescale 1ns/10ps
`default_nettype none
module test_printer_forms_control_buffer;
  import pfc_pkg::*;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic cmd_valid, cmd_ready, cmd_done, load_valid, load_last, load_ready;
  logic feed_step, lpi8, inhibit, table_valid;
  logic car_rdy = 1'b0, par_err = 1'b0, unit_flt = 1'b0, prn_flt = 1'b0, sns_clr = 1'b0;
  pfc_op_t              cmd_op;
  logic [3:0]           cmd_arg;
  logic [ENT_W-1:0]     load_data;
  logic [POS_W-1:0]     line_pos;
  logic [SENSE_W-1:0]   sense;
  int mismatches = 0, compares = 0, feeds = 0, cyc = 0;

  pfc_top i_pfc_top (.clk_i(clk_i), .rst_i(rst_i), .cmd_valid_i(cmd_valid),
    .cmd_op_i(cmd_op), .cmd_arg_i(cmd_arg), .cmd_ready_o(cmd_ready), .cmd_done_o(cmd_done),
    .load_valid_i(load_valid), .load_data_i(load_data), .load_last_i(load_last),
    .load_ready_o(load_ready), .carriage_ready_i(car_rdy), .feed_step_o(feed_step),
    .lpi8_o(lpi8), .line_pos_o(line_pos), .print_parity_err_i(par_err),
    .unit_fault_i(unit_flt), .printer_fault_i(prn_flt), .sense_clear_i(sns_clr),
    .motion_inhibit_o(inhibit), .table_valid_o(table_valid), .sense_o(sense));
  pfc_host_model i_pfc_host_model (.clk_i(clk_i), .cmd_ready_i(cmd_ready),
    .cmd_done_i(cmd_done), .load_ready_i(load_ready), .cmd_valid_o(cmd_valid),
    .cmd_op_o(cmd_op), .cmd_arg_o(cmd_arg), .load_valid_o(load_valid),
    .load_data_o(load_data), .load_last_o(load_last));

  // Clock, and a carriage that stalls one cycle in three
  always #2 clk_i = ~clk_i;
  always @(negedge clk_i) begin
    cyc <= cyc + 1;
    car_rdy <= (cyc % 3) != 2;
  end
  always @(posedge clk_i) begin
    if (feed_step === 1'b1) feeds <= feeds + 1;
  end

  task automatic check(input logic [SENSE_W-1:0] seen, input logic [SENSE_W-1:0] exp);
    compares++;
    if (seen !== exp) begin
      mismatches++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  task automatic print_verdict();
    $display("compares %0d mismatches %0d", compares, mismatches);
    if (mismatches == 0 && compares > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask : print_verdict

  // A hung handshake ends the run
  task automatic need(input logic ok);
    if (!ok) begin
      mismatches++;
      print_verdict();
    end
  endtask : need

  task automatic run(input pfc_op_t op, input logic [3:0] arg);
    int b;
    logic ok;
    feeds = 0;
    i_pfc_host_model.send(op, arg, b);
    i_pfc_host_model.wait_done(b, ok);
    need(ok);
  endtask : run

  task automatic fill(input logic [ENT_W-1:0] q[$]);
    logic ok;
    i_pfc_host_model.load(q, ok);
    need(ok);
  endtask : fill

  task automatic pulse(ref logic s);
    @(negedge clk_i);
    s = 1'b1;
    @(negedge clk_i);
    s = 1'b0;
  endtask : pulse

  // Reset values, then motion refused without a table
  task automatic t_unloaded();
    check({line_pos, lpi8, table_valid}, {POS_FIRST, LPI8_RST, 1'b0});
    check(sense, SENSE_RST);
    run(PFC_OP_SPACE, 4'h1);
    check(feeds, 0);
    check(sense[SNS_NOT_LOADED], 1'b1);
    pulse(sns_clr);
  endtask : t_unloaded

  // No end-of-form flag, then an invalid channel code
  task automatic t_bad_load();
    fill('{6'h01, 6'h02});
    check({table_valid, sense[SNS_LOAD_ERR]}, 2'b01);
    pulse(sns_clr);
    fill('{6'h1d, 6'h10});
    check({table_valid, sense[SNS_LOAD_ERR]}, 2'b01);
    pulse(sns_clr);
  endtask : t_bad_load

  // Six-line form at 8 lpi, channel 5 on line 3, then space and skips
  task automatic t_short_form();
    fill('{6'h20, 6'h00, 6'h05, 6'h00, 6'h00, 6'h10});
    check({table_valid, lpi8, line_pos}, {2'b11, POS_FIRST});
    check(sense, SENSE_RST);
    run(PFC_OP_SPACE, 4'h2);
    check({feeds[7:0], line_pos}, {8'h02, 8'h03});
    run(PFC_OP_SKIP, 4'h5);
    check({feeds[7:0], line_pos}, {8'h06, 8'h03});
    run(PFC_OP_SKIP, 4'h9);
    check({feeds[7:0], line_pos}, {8'h0a, POS_FIRST});
    check(sense[SNS_RUNAWAY], 1'b1);
    pulse(sns_clr);
  endtask : t_short_form

  // Channel codes outside 1 to 12 are refused; no-op and zero-line space move nothing
  task automatic t_reject();
    logic [3:0] bad[2] = '{4'h0, 4'hd};
    foreach (bad[i]) begin
      run(PFC_OP_SKIP, bad[i]);
      check({feeds[7:0], sense[SNS_CMD_REJ]}, 9'h001);
      pulse(sns_clr);
    end
    run(PFC_OP_NOP, 4'h0);
    check({feeds[7:0], line_pos}, {8'h00, POS_FIRST});
    check(sense, SENSE_RST);
    run(PFC_OP_SPACE, 4'h0);
    check({feeds[7:0], line_pos}, {8'h00, POS_FIRST});
  endtask : t_reject

  // Full 180-line form, channel 12 on the last line
  task automatic t_full_form();
    logic [ENT_W-1:0] q[$];
    repeat (LINES - 1) q.push_back(6'h00);
    q.push_back(6'h1c);
    fill(q);
    check({table_valid, lpi8}, 2'b10);
    run(PFC_OP_SKIP, 4'hc);
    check({feeds[7:0], line_pos}, {8'hb3, POS_LAST});
    run(PFC_OP_SPACE, 4'h1);
    check(line_pos, POS_FIRST);
  endtask : t_full_form

  // Parity error stops the carriage until cleared; faults are sensed
  task automatic t_faults();
    int b;
    logic ok;
    pulse(par_err);
    check({inhibit, sense[SNS_PRINT_PARITY]}, 2'b11);
    feeds = 0;
    i_pfc_host_model.send(PFC_OP_SPACE, 4'h1, b);
    repeat (12) @(negedge clk_i);
    check(feeds, 0);
    pulse(sns_clr);
    i_pfc_host_model.wait_done(b, ok);
    need(ok);
    pulse(unit_flt);
    pulse(prn_flt);
    check(sense[SNS_PRINTER_FAULT:SNS_UNIT_FAULT], 2'b11);
    pulse(sns_clr);
    check(inhibit, 1'b0);
    check(sense, SENSE_RST);
  endtask : t_faults

  // Main sequence
  initial begin
    repeat (3) @(negedge clk_i);
    rst_i = 1'b0;
    @(negedge clk_i);
    t_unloaded();
    t_bad_load();
    t_short_form();
    t_reject();
    t_full_form();
    t_faults();
    print_verdict();
  end
endmodule : test_printer_forms_control_buffer
`default_nettype wire
